// ==== fbio_pkg.sv ====
// Constants and types shared by the four-bit port with boot-mode sampling
package fbio_pkg;

  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------
  localparam int NPIN = 4;
  localparam int AW   = 8;
  localparam int BOOT_PIN = 0;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [AW-1:0] A_DATA = 8'h00;
  localparam logic [AW-1:0] A_OE   = 8'h04;
  localparam logic [AW-1:0] A_FUNC = 8'h08;
  localparam logic [AW-1:0] A_OD   = 8'h28;
  localparam logic [AW-1:0] A_PU   = 8'h2C;
  localparam logic [AW-1:0] A_IE   = 8'h38;
  localparam logic [AW-1:0] A_STS  = 8'h40;
  localparam logic [AW-1:0] A_MSK  = 8'h44;
  localparam logic [AW-1:0] A_BOOT = 8'h48;

  // ---------------------------------------------------------------------------
  // Field masks and reset values
  // ---------------------------------------------------------------------------
  localparam logic [NPIN-1:0] FUNC_MASK = 4'hE;
  localparam logic [NPIN-1:0] OD_MASK   = 4'hD;
  localparam logic [NPIN-1:0] PU_MASK   = 4'h1;
  localparam logic [NPIN-1:0] PU_FORCE  = 4'hC;
  localparam logic [NPIN-1:0] OD_FORCE  = 4'h2;
  localparam logic [NPIN-1:0] REG_RST   = 4'h0;
  localparam logic [NPIN-1:0] RST_IE    = 4'h1;
  localparam logic [NPIN-1:0] RST_PU    = 4'hD;
  localparam int IRQ_F_BIT = 3;
  localparam int IRQ_E_BIT = 2;
  localparam int CEC_BIT   = 1;
  localparam int BOOT_CHIP_BIT = 0;
  localparam int BOOT_BOOT_BIT = 1;

  // Boot sampling state
  typedef enum logic [1:0] {BS_RESET, BS_CHIP, BS_BOOT} fbio_boot_e;

endpackage : fbio_pkg

// ==== fbio_port.sv ====
// Four-bit I/O port with alternate functions, boot sampling and APB registers
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
module fbio_port
  import fbio_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [NPIN-1:0]   pin_in,
  output logic      [NPIN-1:0]   pin_out,
  output logic      [NPIN-1:0]   pin_oe,
  output logic      [NPIN-1:0]   pin_ibuf_en,
  output logic      [NPIN-1:0]   pin_pullup,
  input  wire logic              stop_mode,
  input  wire logic              stop_pin_drive,
  output logic                   ext_irq_f_line,
  output logic                   ext_irq_e_line,
  output logic                   cec_in,
  output logic                   boot_single_chip,
  output logic                   boot_single_boot,
  output logic                   irq
);

  // ---------------------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------------------
  if (ADDR_W <= AW) begin : g_chk
    $error("ADDR_W must exceed the decoded offset width");
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [NPIN-1:0] data_reg;
  logic [NPIN-1:0] oe_reg;
  logic [NPIN-1:0] func_reg;
  logic [NPIN-1:0] od_reg;
  logic [NPIN-1:0] pu_reg;
  logic [NPIN-1:0] ie_reg;
  logic [NPIN-1:0] sts_reg;
  logic [NPIN-1:0] msk_reg;
  logic [NPIN-1:0] feed_q;
  fbio_boot_e      boot_st;

  // ---------------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------------
  wire          upper_ok = (paddr[ADDR_W-1:AW] == '0);
  wire [AW-1:0] offs     = paddr[AW-1:0];
  wire          hit_data = upper_ok && (offs == A_DATA);
  wire          hit_oe   = upper_ok && (offs == A_OE);
  wire          hit_func = upper_ok && (offs == A_FUNC);
  wire          hit_od   = upper_ok && (offs == A_OD);
  wire          hit_pu   = upper_ok && (offs == A_PU);
  wire          hit_ie   = upper_ok && (offs == A_IE);
  wire          hit_sts  = upper_ok && (offs == A_STS);
  wire          hit_msk  = upper_ok && (offs == A_MSK);
  wire          hit_boot = upper_ok && (offs == A_BOOT);
  wire          mapped   = hit_data | hit_oe | hit_func | hit_od | hit_pu
                         | hit_ie | hit_sts | hit_msk | hit_boot;

  // One wait state: the answer rises on the second access cycle
  wire          acc_go   = psel && penable && !pready;
  wire          wr_fire  = psel && penable && pready && pwrite && mapped;
  wire [NPIN-1:0] wd     = pwdata[NPIN-1:0];

  // ---------------------------------------------------------------------------
  // Pin-side combinational paths
  // ---------------------------------------------------------------------------
  // Drivers halted while in STOP unless told to keep driving
  wire          halt     = stop_mode && !stop_pin_drive;
  wire          boot_done = (boot_st != BS_RESET);
  wire [NPIN-1:0] od_eff = (od_reg & OD_MASK) | OD_FORCE;
  wire [NPIN-1:0] irq_keep = func_reg & ie_reg;
  // Buffer stays on during a halted STOP only for selected interrupt inputs
  wire [NPIN-1:0] ie_eff = halt ? irq_keep : ie_reg;
  // Outside STOP any enabled input feeds its interrupt path
  wire [NPIN-1:0] feed_en = stop_mode ? irq_keep : ie_reg;
  wire [NPIN-1:0] feed   = pin_in & feed_en & pin_ibuf_en;
  wire [NPIN-1:0] rise   = feed & ~feed_q;
  // Open-drain bits only pull low; CMOS bits drive the data value
  wire [NPIN-1:0] drv_oe = halt ? REG_RST
                         : (oe_reg & ~(od_eff & data_reg));
  wire [NPIN-1:0] drv_val = data_reg & ~od_eff;
  // Boot pin buffer and pull-up held on until the mode is caught
  wire [NPIN-1:0] boot_frc = boot_done ? REG_RST : RST_IE;
  wire [NPIN-1:0] next_ibuf = ie_eff | boot_frc;
  wire [NPIN-1:0] next_pu = (pu_reg & PU_MASK) | PU_FORCE | boot_frc;
  // Read path: enabled bits show the pin, others the stored value
  wire [NPIN-1:0] data_rd = (data_reg & ~pin_ibuf_en)
                          | (pin_in & pin_ibuf_en);
  wire [NPIN-1:0] boot_rd = {2'b00, boot_single_boot, boot_single_chip};
  wire [NPIN-1:0] sts_set = rise;
  wire [NPIN-1:0] sts_clr = (wr_fire && hit_sts) ? wd : REG_RST;
  wire [NPIN-1:0] next_sts = sts_set | (sts_reg & ~sts_clr);
  wire [NPIN-1:0] next_msk = (wr_fire && hit_msk) ? wd : msk_reg;

  // Read multiplexer
  logic [NPIN-1:0] rd_sel;
  always_comb begin
    rd_sel = REG_RST;
    if (hit_data) rd_sel = data_rd;
    if (hit_oe)   rd_sel = oe_reg;
    if (hit_func) rd_sel = func_reg & FUNC_MASK;
    if (hit_od)   rd_sel = od_reg & OD_MASK;
    if (hit_pu)   rd_sel = pu_reg & PU_MASK;
    if (hit_ie)   rd_sel = ie_reg;
    if (hit_sts)  rd_sel = sts_reg;
    if (hit_msk)  rd_sel = msk_reg;
    if (hit_boot) rd_sel = boot_rd;
  end

  // ---------------------------------------------------------------------------
  // APB answer
  // ---------------------------------------------------------------------------
  // Answer flops; read data and error land with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= acc_go;
      pslverr <= acc_go && !mapped;
      if (acc_go) begin
        prdata <= {{(32-NPIN){1'b0}}, (pwrite ? REG_RST : rd_sel)};
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  // Software-written control; all port function, everything off at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg <= REG_RST;
      oe_reg   <= REG_RST;
      func_reg <= REG_RST;
      od_reg   <= REG_RST;
      pu_reg   <= REG_RST;
      ie_reg   <= REG_RST;
      msk_reg  <= REG_RST;
    end else if (wr_fire) begin
      if (hit_data) data_reg <= wd;
      if (hit_oe)   oe_reg   <= wd;
      if (hit_func) func_reg <= wd & FUNC_MASK;
      if (hit_od)   od_reg   <= wd & OD_MASK;
      if (hit_pu)   pu_reg   <= wd & PU_MASK;
      if (hit_ie)   ie_reg   <= wd;
      if (hit_msk)  msk_reg  <= wd;
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt status
  // ---------------------------------------------------------------------------
  // Sticky rise flags; a new rise beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_reg <= REG_RST;
      feed_q  <= REG_RST;
      irq     <= 1'b0;
    end else begin
      sts_reg <= next_sts;
      feed_q  <= feed;
      irq     <= |(next_sts & next_msk);
    end
  end

  // ---------------------------------------------------------------------------
  // Boot-mode sampling
  // ---------------------------------------------------------------------------
  // First edge after reset release catches the boot pin once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_st <= BS_RESET;
    end else begin
      unique case (boot_st)
        BS_RESET: begin
          if (pin_in[BOOT_PIN]) begin
            boot_st <= BS_CHIP;
          end else begin
            boot_st <= BS_BOOT;
          end
        end
        BS_CHIP: boot_st <= BS_CHIP;
        BS_BOOT: boot_st <= BS_BOOT;
        default: boot_st <= BS_RESET;
      endcase
    end
  end

  // Mode outputs follow the caught state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_single_chip <= 1'b0;
      boot_single_boot <= 1'b0;
    end else begin
      boot_single_chip <= (boot_st == BS_CHIP);
      boot_single_boot <= (boot_st == BS_BOOT);
    end
  end

  // ---------------------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------------------
  // Buffer enables start with only the boot pin open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_ibuf_en <= RST_IE;
      pin_pullup  <= RST_PU;
      pin_out     <= REG_RST;
      pin_oe      <= REG_RST;
    end else begin
      pin_ibuf_en <= next_ibuf;
      pin_pullup  <= next_pu;
      pin_out     <= drv_val;
      pin_oe      <= drv_oe;
    end
  end

  // Alternate-function inputs toward the interrupt and CEC logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_f_line <= 1'b0;
      ext_irq_e_line <= 1'b0;
      cec_in         <= 1'b0;
    end else begin
      ext_irq_f_line <= feed[IRQ_F_BIT];
      ext_irq_e_line <= feed[IRQ_E_BIT];
      cec_in         <= feed[CEC_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PU_FIXED: assert property (boot_done |-> pin_pullup[3:2] == 2'b11)
    else $error("pins two and three lost pull-up");

  AST_PIN1_OD: assert property (pin_oe[1] |-> !pin_out[1])
    else $error("pin one driven high");

  AST_BOOT_CHIP: assert property ($rose(boot_done) && $past(pin_in[BOOT_PIN])
    |=> boot_single_chip && !boot_single_boot)
    else $error("high boot pin did not select single-chip");

  AST_BOOT_BOOT: assert property ($rose(boot_done) && !$past(pin_in[BOOT_PIN])
    |=> boot_single_boot && !boot_single_chip)
    else $error("low boot pin did not select single-boot");

  AST_RST_BUF: assert property (!boot_done |=> pin_ibuf_en[0] && pin_pullup[0])
    else $error("boot pin buffer off before mode caught");

  // Reset leaves every bit a port with input enables and drivers off
  AST_RST_STATE: assert property ($rose(boot_done)
    |-> oe_reg == '0 && func_reg == '0 && ie_reg == '0 && pin_oe == '0)
    else $error("port not in reset state after release");

  // ---------------------------------------------------------------------------
  // Pin drive checks
  // ---------------------------------------------------------------------------
  AST_DRIVE: assert property (oe_reg[3] && !od_reg[3] && !halt
    |=> pin_oe[3] && pin_out[3] == $past(data_reg[3]))
    else $error("output bit three not driving data");

  AST_WR_LAND: assert property (wr_fire && hit_oe |=> oe_reg == $past(wd))
    else $error("output control write did not land");

  // Open-drain bit never drives a high level
  AST_OD_PIN0: assert property (od_reg[0] |=> !pin_out[0])
    else $error("open-drain pin zero driven high");

  // A halted STOP releases every pin
  AST_HALT_OFF: assert property (halt |=> pin_oe == '0)
    else $error("pin driven while halted in STOP");

  // Pull-up of pin zero follows its register once the mode is caught
  AST_PU0: assert property (boot_done |=> pin_pullup[0] == $past(pu_reg[0]))
    else $error("pin zero pull-up ignores its register");

  // ---------------------------------------------------------------------------
  // Input and interrupt path checks
  // ---------------------------------------------------------------------------
  AST_STOP_KEEP: assert property (stop_mode && func_reg[2] && ie_reg[2]
    |=> pin_ibuf_en[2])
    else $error("interrupt buffer closed in STOP");

  // Unselected bits lose their buffer while pins are halted
  AST_HALT_BUF: assert property (halt && !func_reg[3] |=> !pin_ibuf_en[3])
    else $error("unselected buffer open while halted");

  // Once the mode is caught and outside a halted STOP, the buffers follow the input control register
  AST_IBUF: assert property (boot_done && !halt |=> pin_ibuf_en == $past(ie_reg))
    else $error("input buffers do not follow input control");

  AST_FEED: assert property (!stop_mode && ie_reg[2] && pin_ibuf_en[2] && pin_in[2]
    |=> ext_irq_e_line)
    else $error("enabled input did not feed interrupt");

  AST_CEC_FEED: assert property (!stop_mode && ie_reg[1] && pin_ibuf_en[1] && pin_in[1]
    |=> cec_in)
    else $error("enabled input did not feed CEC line");

  // A rise fed from input three always sets its status bit
  AST_STS_SET: assert property (rise[IRQ_F_BIT] |=> sts_reg[IRQ_F_BIT])
    else $error("input rise did not set status");

  AST_IRQ: assert property (|(sts_reg & msk_reg) |-> irq)
    else $error("masked status set but irq low");

  // ---------------------------------------------------------------------------
  // Register bus checks
  // ---------------------------------------------------------------------------
  // Answer is a single-cycle pulse
  AST_PREADY: assert property (pready |=> !pready)
    else $error("pready held past one cycle");

  AST_SLVERR: assert property (acc_go && !mapped |=> pready && pslverr && prdata == '0)
    else $error("unmapped access not refused");

  AST_PU_RD: assert property (acc_go && hit_pu && !pwrite
    |=> pready && prdata[31:1] == '0)
    else $error("pull-up upper bits not zero");

  AST_DATA_RD: assert property (acc_go && hit_data && !pwrite |=> prdata[31:NPIN] == '0)
    else $error("data upper bits not zero");

  // Enabled bits read back the pin level
  AST_READ_PIN: assert property (acc_go && hit_data && !pwrite && pin_ibuf_en[3]
    |=> prdata[3] == $past(pin_in[3]))
    else $error("enabled data bit did not read the pin");

  AST_FUNC_RD: assert property (acc_go && hit_func && !pwrite
    |=> prdata[0] == 1'b0 && prdata[31:NPIN] == '0)
    else $error("function bit zero not read as zero");

  AST_OD_RD: assert property (acc_go && hit_od && !pwrite
    |=> prdata[1] == 1'b0 && prdata[31:NPIN] == '0)
    else $error("open-drain bit one not read as zero");

  AST_IE_RD: assert property (acc_go && hit_ie && !pwrite
    |=> prdata[NPIN-1:0] == $past(ie_reg) && prdata[31:NPIN] == '0)
    else $error("input control read-back wrong");

  // ---------------------------------------------------------------------------
  // Coverage of the main scenarios
  // ---------------------------------------------------------------------------
  COV_CHIP: cover property (boot_single_chip);
  COV_BOOT: cover property (boot_single_boot);
  COV_IRQ:  cover property ($rose(irq));
  COV_STOP: cover property (stop_mode && ext_irq_e_line);
  COV_CEC:  cover property (cec_in);

endmodule : fbio_port

// ==== fbio_pins_model.sv ====
// Board-side model of the four port pins: outside drivers, pull-ups, floating lines
`timescale 1ns/100ps
module fbio_pins_model
  import fbio_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic [NPIN-1:0] pin_out,
  input  wire logic [NPIN-1:0] pin_oe,
  input  wire logic [NPIN-1:0] pin_pullup,
  input  wire logic [NPIN-1:0] ext_en,
  input  wire logic [NPIN-1:0] ext_val,
  output logic      [NPIN-1:0] pin_in
);
  logic [NPIN-1:0] flt = 4'h5;

  // Undriven lines without pull-up wander every cycle
  always @(posedge pclk) begin
    flt <= ~flt;
  end

  // Device drive wins, then the outside driver, then the pull-up
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else
        pin_in[i] = pin_pullup[i] ? 1'b1 : flt[i];
    end
  end
endmodule : fbio_pins_model

// ==== fbio_port_tb.sv ====
// Self-checking testbench of the four-bit port
`timescale 1ns/100ps
module fbio_port_tb;
  import fbio_pkg::*;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic            stop_mode, stop_pin_drive, irq_f, irq_e, cec, b_chip, b_boot, irq;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, d;
  logic [NPIN-1:0] pin_in, pin_out, pin_oe, pin_ibuf, pin_pu, ext_en, ext_val;
  logic [32:0]     q[$];
  logic [32:0]     e;
  int              failures, n_tests, seed, k;
  int              cyc = 0;
  localparam logic [7:0] RA [6] = '{A_DATA, A_OE, A_FUNC, A_OD, A_PU, A_IE};
  localparam logic [3:0] RM [6] = '{4'hF, 4'hF, 4'hE, 4'hD, 4'h1, 4'hF};

  fbio_port u_fbio_port (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_ibuf_en(pin_ibuf),
    .pin_pullup(pin_pu), .stop_mode(stop_mode), .stop_pin_drive(stop_pin_drive),
    .ext_irq_f_line(irq_f), .ext_irq_e_line(irq_e), .cec_in(cec),
    .boot_single_chip(b_chip), .boot_single_boot(b_boot), .irq(irq)
  );

  fbio_pins_model u_fbio_pins_model (
    .pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pu),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in)
  );

  // ---------------------------------------------------------------------------
  // Clock, timeout and checking
  // ---------------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Cuts a hang short
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end

  // Takes the oldest expected answer off the queue at each finished transfer
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      e = q.pop_front();
      chk({pslverr, pwrite ? 32'h0 : prdata}, e);
    end
  end

  task chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // One APB transfer; the answer is noted before the request goes out
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [32:0] ex);
    @(posedge pclk);
    q.push_back(ex);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= 12'(a);
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, 33'h0);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {1'b0, x});
  endtask : rd

  task w8(input int n);
    repeat (n) @(negedge pclk);
  endtask : w8

  task drv(input logic [3:0] v);
    @(posedge pclk);
    ext_val <= v;
    w8(4);
  endtask : drv

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {seed, failures, n_tests} = {32'd82, 32'd0, 32'd0};
    {psel, penable, pwrite, paddr, pwdata, presetn, stop_mode} = '0;
    stop_pin_drive = 1'b1;
    ext_en = 4'hE;
    ext_val = 4'h0;
    w8(2);
    chk(33'({pin_ibuf, pin_pu, pin_oe}), 33'h1D0);
    w8(3);
    @(posedge pclk) presetn <= 1'b1;
    w8(3);
    chk(33'({b_boot, b_chip}), 33'h1);
    @(posedge pclk) ext_en <= 4'hF;
    rd(A_BOOT, 32'h1);
    for (k = 0; k < 6; k++) begin
      rd(RA[k], 32'h0);
      wr(RA[k], 32'hFFFFFFFF);
      rd(RA[k], 32'(RM[k]));
      wr(RA[k], 32'h0);
    end
    apb(1'b0, 8'h30, 32'h0, 33'h100000000);
    wr(A_OE, 32'hF);
    w8(2);
    chk(33'(pin_pu), 33'hC);
    for (k = 0; k < 6; k++) begin
      d = $random(seed);
      wr(A_DATA, {28'h0, d[3:0]});
      w8(2);
      chk(33'({~(d[3:0] & 4'h2), d[3:0] & 4'hD}), 33'({pin_oe, pin_out}));
    end
    wr(A_OD, 32'hF);
    wr(A_DATA, 32'hF);
    w8(2);
    chk(33'({pin_oe, pin_out}), 33'h0);
    wr(A_PU, 32'h1);
    w8(2);
    chk(33'(pin_pu), 33'hD);
    wr(A_OE, 32'h0);
    wr(A_IE, 32'hF);
    wr(A_MSK, 32'hF);
    drv(4'h8);
    chk(33'({irq, irq_f}), 33'h3);
    rd(A_DATA, 32'h8);
    rd(A_STS, 32'h8);
    wr(A_MSK, 32'h0);
    w8(3);
    chk(33'(irq), 33'h0);
    wr(A_STS, 32'h8);
    rd(A_STS, 32'h0);
    drv(4'h0);
    @(posedge pclk);
    stop_mode <= 1'b1;
    stop_pin_drive <= 1'b0;
    wr(A_FUNC, 32'h4);
    drv(4'hC);
    chk(33'({irq_e, irq_f}), 33'h2);
    @(posedge pclk) stop_mode <= 1'b0;
    w8(4);
    chk(33'({irq_e, irq_f}), 33'h3);
    drv(4'h2);
    chk(33'({cec, irq_e, irq_f}), 33'h4);
    wr(A_IE, 32'h0);
    @(posedge pclk) presetn <= 1'b0;
    w8(5);
    @(posedge pclk) presetn <= 1'b1;
    w8(3);
    chk(33'({b_boot, b_chip, pin_ibuf}), 33'h20);
    rd(A_BOOT, 32'h2);
    w8(2);
    give_verdict();
  end
endmodule : fbio_port_tb
